/* File: hw/lcc_charger.sv */
// Charge controller: phase sequencing, timers, supply-valid output and AXI4-Lite registers
// Functional notes
// (R1) Low cell at start: precharge at tenth current
// (R2) Precharge timer expiry: stop, fault, detect current
// (R3) Fault held until reset, new cell, clear
// (R4) USB current 100 or 500 mA, 100 default
// (R5) 25% reduction steps apply to AC only
// (R6) Fast timer expiry without taper: fault, stop
// (R7) Leaving voltage regulation resets fast timer
// (R8) Timers disabled until setup bit 5 set; the precharge timer runs regardless of bit 5
// (R9) Taper reached: start taper timer, then terminate
// (R10) Current above taper resets taper timer
// (R11) Restart charge below recharge level
// (R12) Thermal suspend holds both timer counts
// (R13) Below termination current: terminate at once
// (R14) New cell: charge, clear taper/term flags, release
// (R15) Both inputs absent: sleep
// (R16) Supply valid when AC or USB valid
// (R17) Off in sleep; AC overvoltage invalid
// (R18) Charger reset bit: supply-valid high impedance
// (R19) Supply-valid follows charger or indicator regs
// (R20) Suspend charging while junction too hot; precharge current keeps flowing while hot
// (R21) Strap pins choose converter default voltages
// (R22) Deep-sleep request gated by allow bit
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "lcc_defines.svh"

module lcc_charger
	import lcc_pkg::*;
#(
	parameter int unsigned PRE_CYC = `LCC_PRE_CYC,
	parameter int unsigned CHG_CYC = `LCC_CHG_CYC,
	parameter int unsigned TAPER_CYC = `LCC_TAPER_CYC,
	parameter int unsigned TICK_CYC = `LCC_IND_TICK_CYC
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire lcc_axi_req_t axi_req,
	output lcc_axi_rsp_t axi_rsp,
	// Analog comparator pins
	input wire lcc_sense_t sense_pin,
	input wire logic main_default_strap,
	input wire logic core_default_strap,
	// Charger drive
	output logic charge_on,
	output logic [7:0] charge_level,
	output logic detect_current,
	output logic interrupt_out,
	// Supply-valid open-drain pin
	output logic supply_valid_out,
	output logic supply_valid_oe,
	// Converter targets
	output logic [7:0] main_target,
	output logic [7:0] core_target,
	output logic core_enable
);

	typedef struct packed {
		lcc_sense_t s1;
		lcc_sense_t s2;
		logic strap_done;
		logic [1:0] strap_s1;
		logic [1:0] strap_s2;
		lcc_phase_t phase;
		logic [31:0] tmr_a;
		logic [31:0] tmr_fast;
		logic [31:0] tmr_taper;
		logic [6:0] flags;
		logic [7:0] setup;
		logic [7:0] buck1;
		logic [7:0] buck2;
		logic [7:0] ind_on;
		logic [7:0] ind_per;
		logic [31:0] tick;
		logic [7:0] ind_cnt;
		logic [7:0] main_t;
		logic [7:0] core_t;
		logic aw_got;
		logic [7:0] aw_a;
		logic w_got;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] cur;
		logic sv_on;
	} lcc_state_t;

	lcc_state_t st_r;
	lcc_state_t st_nxt;
	lcc_sense_t sn;
	logic chg_rst;
	logic in_ok;
	logic tmr_en;
	logic [7:0] ac_cur;

	assign sn = st_r.s2;
	assign chg_rst = st_r.setup[`LCC_SETUP_CHG_RESET];
	assign tmr_en = st_r.setup[`LCC_SETUP_TIMER_EN]; // R8
	assign in_ok = (sn.ac_valid && !sn.ac_ovlo) || sn.usb_valid; // R16 R17

	////////////////////////////////////////////////////////////////////
	// Current level per source
	always_comb begin
		case (st_r.setup[`LCC_SETUP_RED_LO +: 2]) // R5
			2'b01: ac_cur = 8'(`LCC_CUR_FULL - (`LCC_CUR_FULL >> 2));
			2'b10: ac_cur = 8'(`LCC_CUR_FULL >> 1);
			2'b11: ac_cur = 8'(`LCC_CUR_FULL >> 2);
			default: ac_cur = `LCC_CUR_FULL;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [31:0] v;
		logic wr;
		logic rd;
		logic [7:0] full;
		v = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		full = 8'h00;
		st_nxt = st_r;
		st_nxt.s1 = sense_pin;
		st_nxt.s2 = st_r.s1;
		// Straps caught once after reset release
		if (!st_r.strap_done) begin
			st_nxt.strap_done = 1'b1;
			st_nxt.main_t = st_r.strap_s2[1] ? `LCC_MAIN_HI : `LCC_MAIN_LO; // R21
			st_nxt.core_t = st_r.strap_s2[0] ? `LCC_CORE_HI : `LCC_CORE_LO; // R21
		end

		full = (sn.ac_valid && !sn.ac_ovlo) ? ac_cur : // R17
			!sn.usb_valid ? 8'h00 : // R17
			(st_r.setup[`LCC_SETUP_USB500] ? `LCC_CUR_USB500 : `LCC_CUR_USB100); // R4

		// Charge phases
		if (chg_rst) begin
			st_nxt.phase = LCC_IDLE;
		end else if (!sn.ac_valid && !sn.usb_valid) begin
			st_nxt.phase = LCC_SLEEP; // R15
		end else if (sn.batt_new && sn.below_rch && st_r.phase != LCC_PRE && st_r.phase != LCC_FAST) begin
			st_nxt.phase = sn.below_lowv ? LCC_PRE : LCC_FAST; // R14
			st_nxt.flags[`LCC_ST_TAPER] = 1'b0; // R14
			st_nxt.flags[`LCC_ST_TERM] = 1'b0; // R14
			st_nxt.flags[`LCC_ST_FAULT] = 1'b0; // R3
			st_nxt.tmr_a = 32'h0;
			st_nxt.tmr_fast = 32'h0;
			st_nxt.tmr_taper = 32'h0;
		end else begin
			case (st_r.phase)
				LCC_SLEEP, LCC_IDLE: begin
					if (in_ok) begin
						st_nxt.phase = sn.below_lowv ? LCC_PRE : LCC_FAST; // R1
						st_nxt.tmr_a = 32'h0;
						st_nxt.tmr_fast = 32'h0;
						st_nxt.tmr_taper = 32'h0;
					end
				end
				LCC_PRE: begin
					if (!sn.below_lowv) begin
						st_nxt.phase = LCC_FAST;
					end else if (!sn.hot) begin
						if (st_r.tmr_a >= PRE_CYC - 1) begin
							st_nxt.phase = LCC_FAULT; // R2
							st_nxt.flags[`LCC_ST_FAULT] = 1'b1; // R2
						end else begin
							st_nxt.tmr_a = st_r.tmr_a + 32'd1;
						end
					end
				end
				LCC_FAST: begin
					if (sn.below_term && sn.at_taper) begin
						st_nxt.phase = LCC_DONE; // R13
						st_nxt.flags[`LCC_ST_TERM] = 1'b1;
					end else if (!sn.hot && tmr_en) begin // R12
						if (!sn.at_taper) begin
							st_nxt.tmr_taper = 32'h0; // R10
							if (st_r.tmr_fast >= CHG_CYC - 1) begin
								st_nxt.phase = LCC_FAULT; // R6
								st_nxt.flags[`LCC_ST_FAULT] = 1'b1; // R6
							end else begin
								st_nxt.tmr_fast = st_r.tmr_fast + 32'd1;
							end
						end else if (st_r.tmr_taper >= TAPER_CYC - 1) begin
							st_nxt.phase = LCC_DONE; // R9
							st_nxt.flags[`LCC_ST_TAPER] = 1'b1;
						end else begin
							st_nxt.tmr_taper = st_r.tmr_taper + 32'd1; // R9
						end
					end
					if (sn.below_lowv) begin
						st_nxt.tmr_fast = 32'h0; // R7
						st_nxt.tmr_taper = 32'h0;
					end
				end
				LCC_DONE: begin
					if (sn.below_rch) begin
						st_nxt.phase = LCC_FAST; // R11
						st_nxt.tmr_fast = 32'h0;
						st_nxt.tmr_taper = 32'h0;
					end
				end
				LCC_FAULT: begin
					if (!st_r.flags[`LCC_ST_FAULT]) begin
						st_nxt.phase = LCC_IDLE; // R3
					end
				end
				default: st_nxt.phase = LCC_IDLE;
			endcase
		end
		st_nxt.flags[`LCC_ST_PRE] = (st_nxt.phase == LCC_PRE);
		st_nxt.flags[`LCC_ST_FAST] = (st_nxt.phase == LCC_FAST);
		st_nxt.flags[`LCC_ST_SLEEP] = (st_nxt.phase == LCC_SLEEP);
		st_nxt.flags[`LCC_ST_THERM] = sn.hot;

		// Drive level: tenth in precharge
		case (st_nxt.phase)
			LCC_PRE: st_nxt.cur = full / 8'd10; // R1
			LCC_FAST: st_nxt.cur = sn.hot ? 8'h00 : full; // R20
			default: st_nxt.cur = 8'h00;
		endcase

		// Supply-valid: charger or indicator timing
		st_nxt.tick = (st_r.tick >= TICK_CYC - 1) ? 32'h0 : st_r.tick + 32'd1;
		if (st_r.tick >= TICK_CYC - 1) begin
			st_nxt.ind_cnt = (st_r.ind_cnt >= st_r.ind_per) ? 8'h00 : st_r.ind_cnt + 8'h01;
		end
		if (st_r.ind_per == 8'h00 && st_r.ind_on == 8'h00) begin
			st_nxt.sv_on = in_ok && st_r.phase != LCC_SLEEP; // R16 R17 R19
		end else begin
			st_nxt.sv_on = (st_r.ind_cnt < st_r.ind_on); // R19
		end

		// Register writes
		wr = st_r.aw_got && st_r.w_got && !st_r.bvalid;
		if (axi_req.awvalid && !st_r.aw_got) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.aw_a = axi_req.awaddr[7:0];
		end
		if (axi_req.wvalid && !st_r.w_got) begin
			st_nxt.w_got = 1'b1;
			st_nxt.w_d = axi_req.wdata;
			st_nxt.w_s = axi_req.wstrb;
		end
		if (wr) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = 2'b00;
			if (st_r.w_s[0]) begin
				case (st_r.aw_a)
					`LCC_OFF_STATUS: st_nxt.flags[`LCC_ST_FAULT] = st_nxt.flags[`LCC_ST_FAULT] &
						!(st_r.w_d[`LCC_ST_FAULT] && st_nxt.phase == st_r.phase); // R3
					`LCC_OFF_SETUP: st_nxt.setup = st_r.w_d[7:0];
					`LCC_OFF_BUCK1: st_nxt.buck1 = st_r.w_d[7:0];
					`LCC_OFF_BUCK2: st_nxt.buck2 = st_r.w_d[7:0];
					`LCC_OFF_IND_ON: st_nxt.ind_on = st_r.w_d[7:0];
					`LCC_OFF_IND_PER: st_nxt.ind_per = st_r.w_d[7:0];
					`LCC_OFF_CURRENT: st_nxt.bresp = 2'b00;
					default: st_nxt.bresp = 2'b10;
				endcase
			end
		end
		if (st_r.bvalid && axi_req.bready) begin
			st_nxt.bvalid = 1'b0;
		end

		// Register reads
		rd = axi_req.arvalid && !st_r.rvalid;
		if (rd) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = 2'b00;
			case (axi_req.araddr[7:0])
				`LCC_OFF_STATUS: v = {25'h0, st_r.flags};
				`LCC_OFF_SETUP: v = {24'h0, st_r.setup};
				`LCC_OFF_BUCK1: v = {24'h0, st_r.buck1};
				`LCC_OFF_BUCK2: v = {24'h0, st_r.buck2};
				`LCC_OFF_IND_ON: v = {24'h0, st_r.ind_on};
				`LCC_OFF_IND_PER: v = {24'h0, st_r.ind_per};
				`LCC_OFF_CURRENT: v = {21'h0, st_r.phase, st_r.cur};
				default: begin
					v = 32'h0;
					st_nxt.rresp = 2'b10;
				end
			endcase
			st_nxt.rdata = v;
		end
		if (st_r.rvalid && axi_req.rready) begin
			st_nxt.rvalid = 1'b0;
		end

		if (!aresetn) begin
			st_nxt = '0;
			st_nxt.phase = LCC_SLEEP;
			st_nxt.setup = `LCC_SETUP_RST; // R4 R8
			st_nxt.buck1 = `LCC_BUCK1_RST;
			st_nxt.buck2 = `LCC_BUCK2_RST;
			st_nxt.ind_on = `LCC_IND_RST;
			st_nxt.ind_per = `LCC_IND_RST;
		end
		// Strap synchroniser runs through reset so straps are settled at release
		st_nxt.strap_s1 = {main_default_strap, core_default_strap};
		st_nxt.strap_s2 = st_r.strap_s1;
	end

	always_ff @(posedge aclk) begin
		st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	always_comb begin
		axi_rsp = '0;
		axi_rsp.awready = !st_r.aw_got;
		axi_rsp.wready = !st_r.w_got;
		axi_rsp.bvalid = st_r.bvalid;
		axi_rsp.bresp = st_r.bresp;
		axi_rsp.arready = !st_r.rvalid;
		axi_rsp.rvalid = st_r.rvalid;
		axi_rsp.rdata = st_r.rdata;
		axi_rsp.rresp = st_r.rresp;
	end

	assign charge_on = (st_r.cur != 8'h00);
	assign charge_level = st_r.cur;
	assign detect_current = (st_r.phase == LCC_FAULT); // R2 R6
	assign interrupt_out = st_r.flags[`LCC_ST_FAULT] | st_r.flags[`LCC_ST_TAPER] | st_r.flags[`LCC_ST_TERM]; // R14
	assign supply_valid_out = 1'b0;
	assign supply_valid_oe = st_r.sv_on && !chg_rst; // R18
	assign main_target = st_r.main_t;
	// Deep-sleep request only acts with allow bit
	assign core_target = (sn.deep_sleep_request && st_r.buck1[`LCC_BUCK1_LP_EN]) ? // R22
		{1'b0, st_r.buck2[6:0]} : st_r.core_t;
	assign core_enable = !(sn.deep_sleep_request && st_r.buck1[`LCC_BUCK1_LP_EN] &&
		st_r.buck2[`LCC_BUCK2_LP_OFF]); // R22

	////////////////////////////////////////////////////////////////////
	// Checks
	a_fault_stops: assert property (@(posedge aclk) disable iff (!aresetn) // R2
		st_r.phase == LCC_FAULT |-> !charge_on && detect_current) else $error("charging in fault");
	a_sleep_no_sv: assert property (@(posedge aclk) disable iff (!aresetn) // R17
		st_r.phase == LCC_SLEEP && st_r.ind_on == 8'h00 && st_r.ind_per == 8'h00 |=> !supply_valid_oe)
		else $error("supply valid in sleep");
	a_reset_hiz: assert property (@(posedge aclk) disable iff (!aresetn) // R18
		chg_rst |-> !supply_valid_oe) else $error("pin driven in charger reset");
	a_hot_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R12
		sn.hot && st_r.phase == LCC_FAST && st_nxt.phase == LCC_FAST |=> $stable(st_r.tmr_fast))
		else $error("timer moved while hot");
	a_timer_off: assert property (@(posedge aclk) disable iff (!aresetn) // R8
		!tmr_en && st_r.phase == LCC_FAST |=> st_r.tmr_fast == $past(st_r.tmr_fast) || st_r.tmr_fast == 32'h0)
		else $error("timer ran disabled");
	a_hot_off: assert property (@(posedge aclk) disable iff (!aresetn) // R20
		st_r.phase == LCC_FAST && sn.hot ##1 st_r.phase == LCC_FAST |-> st_r.cur == 8'h00)
		else $error("charging while hot");
	a_both_gone: assert property (@(posedge aclk) disable iff (!aresetn) // R15
		!sn.ac_valid && !sn.usb_valid && !chg_rst |=> st_r.phase == LCC_SLEEP) else $error("no sleep");
	a_lp_gate: assert property (@(posedge aclk) disable iff (!aresetn) // R22
		!st_r.buck1[`LCC_BUCK1_LP_EN] |-> core_enable && core_target == st_r.core_t)
		else $error("sleep request not gated");
	a_no_source_off: assert property (@(posedge aclk) disable iff (!aresetn) // R17
		!in_ok |=> !charge_on)
		else $error("charging with no valid input");

endmodule
`default_nettype wire

/* File: hw/lcc_defines.svh */
// Register offsets, field positions, reset values and timing counts of the charge controller
`ifndef LCC_DEFINES_SVH
`define LCC_DEFINES_SVH

`define LCC_OFF_STATUS 8'h00
`define LCC_OFF_SETUP 8'h04
`define LCC_OFF_BUCK1 8'h08
`define LCC_OFF_BUCK2 8'h0C
`define LCC_OFF_IND_ON 8'h10
`define LCC_OFF_IND_PER 8'h14
`define LCC_OFF_CURRENT 8'h18

`define LCC_SETUP_RST 8'h00
`define LCC_SETUP_USB500 1
`define LCC_SETUP_RED_LO 2
`define LCC_SETUP_TIMER_EN 5
`define LCC_SETUP_CHG_RESET 6
`define LCC_BUCK1_RST 8'h00
`define LCC_BUCK1_LP_EN 5
`define LCC_BUCK2_RST 8'h00
`define LCC_BUCK2_LP_OFF 7
`define LCC_IND_RST 8'h00

`define LCC_ST_FAULT 0
`define LCC_ST_TAPER 1
`define LCC_ST_TERM 2
`define LCC_ST_PRE 3
`define LCC_ST_FAST 4
`define LCC_ST_SLEEP 5
`define LCC_ST_THERM 6

`define LCC_MAIN_LO 8'h1E
`define LCC_MAIN_HI 8'h21
`define LCC_CORE_LO 8'h0F
`define LCC_CORE_HI 8'h12

`define LCC_CUR_FULL 8'hFF
`define LCC_CUR_USB100 8'h1A
`define LCC_CUR_USB500 8'h80

// Plain default timer lengths in cycles; 32-bit timers cap them
`define LCC_PRE_CYC 32'd1500000000
`define LCC_CHG_CYC 32'd4000000000
`define LCC_TAPER_CYC 32'd1500000000
`define LCC_CLK_KHZ 50000
`define LCC_IND_TICK_US 10000
`define LCC_IND_TICK_CYC ((`LCC_IND_TICK_US * `LCC_CLK_KHZ) / 1000)

`endif

/* File: hw/lcc_pkg.sv */
// Types of the charge controller
package lcc_pkg;
	typedef enum logic [2:0] {
		LCC_SLEEP = 3'b000,
		LCC_PRE = 3'b001,
		LCC_FAST = 3'b010,
		LCC_DONE = 3'b011,
		LCC_FAULT = 3'b100,
		LCC_IDLE = 3'b101
	} lcc_phase_t;

	typedef struct packed {
		logic ac_valid;
		logic usb_valid;
		logic ac_ovlo;
		logic below_lowv;
		logic below_rch;
		logic at_taper;
		logic below_term;
		logic hot;
		logic batt_new;
		logic deep_sleep_request;
	} lcc_sense_t;

	typedef struct packed {
		logic [31:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [31:0] araddr;
		logic arvalid;
		logic rready;
	} lcc_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} lcc_axi_rsp_t;
endpackage

/* File: verif/lcc_host_model.sv */
// Host side AXI4-Lite master model of the charge controller
`timescale 1ns/1ps
`default_nettype none

module lcc_host_model
	import lcc_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Register bus
	output lcc_axi_req_t axi_req,
	input wire lcc_axi_rsp_t axi_rsp
);
	initial axi_req = '0;

	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		axi_req.awaddr <= a;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hF;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && axi_rsp.awready === 1'b1) begin
				aw = 1'b1;
				axi_req.awvalid <= 1'b0;
			end
			if (!w && axi_rsp.wready === 1'b1) begin
				w = 1'b1;
				axi_req.wvalid <= 1'b0;
			end
		end
		while (axi_rsp.bvalid !== 1'b1) @(posedge aclk);
		r = axi_rsp.bresp;
		axi_req.bready <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		do @(posedge aclk); while (axi_rsp.arready !== 1'b1);
		axi_req.arvalid <= 1'b0;
		while (axi_rsp.rvalid !== 1'b1) @(posedge aclk);
		d = axi_rsp.rdata;
		r = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
	endtask
endmodule

`default_nettype wire

/* File: verif/test_lcc_charger.sv */
// Self-checking testbench of the charge controller
`timescale 1ns/1ps
`default_nettype none
`include "lcc_defines.svh"

module test_lcc_charger
	import lcc_pkg::*;
;
	logic aclk;
	logic aresetn;
	lcc_axi_req_t axi_req;
	lcc_axi_rsp_t axi_rsp;
	lcc_sense_t s;
	logic ms;
	logic cs;
	logic charge_on;
	logic [7:0] charge_level;
	logic detect_current;
	logic interrupt_out;
	logic supply_valid_out;
	logic supply_valid_oe;
	logic [7:0] main_target;
	logic [7:0] core_target;
	logic core_enable;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	int hi;
	logic [31:0] d;
	logic [1:0] r;

	lcc_charger #(.PRE_CYC(20), .CHG_CYC(40), .TAPER_CYC(10), .TICK_CYC(2)) i_lcc_charger (
		.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .sense_pin(s),
		.main_default_strap(ms), .core_default_strap(cs), .charge_on(charge_on),
		.charge_level(charge_level), .detect_current(detect_current), .interrupt_out(interrupt_out),
		.supply_valid_out(supply_valid_out), .supply_valid_oe(supply_valid_oe),
		.main_target(main_target), .core_target(core_target), .core_enable(core_enable)
	);
	lcc_host_model i_lcc_host_model (.aclk(aclk), .axi_req(axi_req), .axi_rsp(axi_rsp));

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task chk(input string n, input logic [31:0] v, input logic [31:0] e);
		total_checks++;
		if (v !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, v);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		i_lcc_host_model.wr({24'h000000, a}, v, r);
		chk("bresp", r, 32'h00000000);
	endtask

	task rs(input int b, input logic e);
		i_lcc_host_model.rd({24'h000000, `LCC_OFF_STATUS}, d, r);
		chk("status bit", d[b], e);
	endtask

	task sn(input logic [9:0] v);
		@(posedge aclk);
		s <= lcc_sense_t'(v);
		repeat (6) @(posedge aclk);
	endtask

	task rst;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		aresetn = 1'b0;
		s = '0;
		ms = 1'b0;
		cs = 1'b0;
		rst();
		chk("main_target", main_target, 32'h0000001E);
		chk("core_target", core_target, 32'h0000000F);
		i_lcc_host_model.rd({24'h000000, `LCC_OFF_SETUP}, d, r);
		chk("setup reset", d, 32'h00000000);
		i_lcc_host_model.rd({24'h000000, `LCC_OFF_IND_ON}, d, r);
		chk("indicator reset", d, 32'h00000000);
		i_lcc_host_model.rd(32'h0000001C, d, r);
		chk("unmapped resp", r, 32'h00000002);
		chk("unmapped data", d, 32'h00000000);
		rs(`LCC_ST_SLEEP, 1'b1);
		chk("oe sleep", supply_valid_oe, 32'h00000000);
		// Low cell on AC: precharge then timer fault
		sn(10'h240);
		rs(`LCC_ST_PRE, 1'b1);
		chk("pre level", charge_level, 32'h00000019);
		repeat (30) @(posedge aclk);
		rs(`LCC_ST_FAULT, 1'b1);
		chk("detect", detect_current, 32'h00000001);
		chk("charge off", charge_on, 32'h00000000);
		sn(10'h200);
		rs(`LCC_ST_FAULT, 1'b1);
		wr(`LCC_OFF_STATUS, 32'h00000001);
		rs(`LCC_ST_FAULT, 1'b0);
		repeat (6) @(posedge aclk);
		chk("ac full", charge_level, 32'h000000FF);
		wr(`LCC_OFF_SETUP, 32'h00000004);
		repeat (4) @(posedge aclk);
		chk("ac reduced", charge_level < 8'hFF, 32'h00000001);
		wr(`LCC_OFF_SETUP, 32'h00000008);
		repeat (4) @(posedge aclk);
		chk("ac half", charge_level, 32'h0000007F);
		i_lcc_host_model.rd({24'h000000, `LCC_OFF_CURRENT}, d, r);
		chk("level reg", d, 32'h0000027F);
		sn(10'h100);
		chk("usb 100", charge_level, 32'h0000001A);
		wr(`LCC_OFF_SETUP, 32'h00000006);
		repeat (4) @(posedge aclk);
		chk("usb 500", charge_level, 32'h00000080);
		sn(10'h104);
		chk("hot off", charge_on, 32'h00000000);
		rs(`LCC_ST_THERM, 1'b1);
		sn(10'h100);
		repeat (60) @(posedge aclk);
		rs(`LCC_ST_FAULT, 1'b0);
		// Fast timer held across thermal suspend
		wr(`LCC_OFF_SETUP, 32'h00000026);
		repeat (20) @(posedge aclk);
		sn(10'h104);
		repeat (40) @(posedge aclk);
		sn(10'h100);
		repeat (18) @(posedge aclk);
		rs(`LCC_ST_FAULT, 1'b1);
		// Taper timer restart, then expiry
		sn(10'h110);
		wr(`LCC_OFF_STATUS, 32'h00000001);
		repeat (5) @(posedge aclk);
		sn(10'h100);
		sn(10'h110);
		repeat (4) @(posedge aclk);
		chk("taper restart", charge_on, 32'h00000001);
		repeat (10) @(posedge aclk);
		chk("taper end", charge_on, 32'h00000000);
		sn(10'h120);
		chk("recharge", charge_on, 32'h00000001);
		sn(10'h118);
		chk("term off", charge_on, 32'h00000000);
		chk("int term", interrupt_out, 32'h00000001);
		rs(`LCC_ST_TERM, 1'b1);
		sn(10'h122);
		rs(`LCC_ST_TERM, 1'b0);
		rs(`LCC_ST_TAPER, 1'b0);
		chk("int released", interrupt_out, 32'h00000000);
		chk("new cell charge", charge_on, 32'h00000001);
		wr(`LCC_OFF_SETUP, 32'h00000002);
		sn(10'h100);
		chk("oe usb", supply_valid_oe, 32'h00000001);
		chk("sv pin low", supply_valid_out, 32'h00000000);
		wr(`LCC_OFF_SETUP, 32'h00000040);
		repeat (3) @(posedge aclk);
		chk("oe chg reset", supply_valid_oe, 32'h00000000);
		wr(`LCC_OFF_SETUP, 32'h00000000);
		sn(10'h280);
		chk("oe ovlo", supply_valid_oe, 32'h00000000);
		chk("ovlo off", charge_on, 32'h00000000);
		// Indicator blink
		sn(10'h100);
		wr(`LCC_OFF_IND_ON, 32'h00000001);
		wr(`LCC_OFF_IND_PER, 32'h00000004);
		hi = 0;
		repeat (40) begin
			@(posedge aclk);
			hi += (supply_valid_oe === 1'b1);
		end
		chk("blink", hi > 0 && hi < 40, 32'h00000001);
		// Deep sleep request gating
		sn(10'h101);
		wr(`LCC_OFF_BUCK2, 32'h0000000A);
		repeat (3) @(posedge aclk);
		chk("lp ignored", core_target, 32'h0000000F);
		wr(`LCC_OFF_BUCK1, 32'h00000020);
		repeat (3) @(posedge aclk);
		chk("lp core", core_target, 32'h0000000A);
		chk("lp enable", core_enable, 32'h00000001);
		wr(`LCC_OFF_BUCK2, 32'h0000008A);
		repeat (3) @(posedge aclk);
		chk("lp disable", core_enable, 32'h00000000);
		ms <= 1'b1;
		cs <= 1'b1;
		rst();
		chk("main high", main_target, 32'h00000021);
		chk("core high", core_target, 32'h00000012);
		finish_test();
	end
endmodule

`default_nettype wire
